// [hw/fec_consts.vh]
`ifndef FEC_CONSTS_VH
`define FEC_CONSTS_VH

// clock and bus timing
`define FEC_CLK_NS 20
`define FEC_T_WP_NS 35
`define FEC_T_RD_NS 55
`define FEC_T_BUSY_NS 90
`define FEC_WP_CYC ((`FEC_T_WP_NS + `FEC_CLK_NS - 1) / `FEC_CLK_NS)
`define FEC_RD_CYC ((`FEC_T_RD_NS + `FEC_CLK_NS - 1) / `FEC_CLK_NS)
`define FEC_BUSY_CYC ((`FEC_T_BUSY_NS + `FEC_CLK_NS - 1) / `FEC_CLK_NS)

// user operation codes
`define FEC_OP_READ 4'h0
`define FEC_OP_SECTOR_ERASE 4'h1
`define FEC_OP_SUSPEND 4'h2
`define FEC_OP_RESUME 4'h3
`define FEC_OP_BYP_ENTER 4'h4
`define FEC_OP_BYP_PROG 4'h5
`define FEC_OP_BYP_EXIT 4'h6
`define FEC_OP_RESET 4'h7
`define FEC_OP_PROT_VERIFY 4'h8

// unlock addresses and protect offsets, byte and word mode
`define FEC_UNLOCK1_BYTE 20'h00AAA
`define FEC_UNLOCK2_BYTE 20'h00555
`define FEC_UNLOCK1_WORD 20'h00555
`define FEC_UNLOCK2_WORD 20'h002AA
`define FEC_PROT_OFS_BYTE 20'h00004
`define FEC_PROT_OFS_WORD 20'h00002

// command data codes
`define FEC_D_UNLOCK1 8'hAA
`define FEC_D_UNLOCK2 8'h55
`define FEC_D_ERASE_SETUP 8'h80
`define FEC_D_SECTOR_ERASE 8'h30
`define FEC_D_SUSPEND 8'hB0
`define FEC_D_RESUME 8'h30
`define FEC_D_BYP_ENTER 8'h20
`define FEC_D_BYP_PROG 8'hA0
`define FEC_D_BYP_EXIT1 8'h90
`define FEC_D_BYP_EXIT2 8'h00
`define FEC_D_RESET 8'hF0
`define FEC_D_AUTOSELECT 8'h90

// status bit carrying the timeout-exceeded flag
`define FEC_TIMEOUT_BIT 5

`endif

// [hw/fec_bus_cycle.v]
`timescale 1ns/1ps
`include "fec_consts.vh"
module fec_bus_cycle #(
    parameter WP_CYC = `FEC_WP_CYC,
    parameter RD_CYC = `FEC_RD_CYC
) (
    input wire core_clk,
    input wire rstn,
    input wire start,
    input wire rd,
    input wire [19:0] addr,
    input wire [15:0] wdata,
    output reg done,
    output reg [15:0] rdata,
    output reg [19:0] flash_addr,
    output reg [15:0] flash_dq_out,
    input wire [15:0] flash_dq_in,
    output reg flash_dq_oe_n,
    output reg flash_ce_n,
    output reg flash_oe_n,
    output reg flash_we_n
);
localparam ST_IDLE = 3'h0;
localparam ST_SETUP = 3'h1;
localparam ST_STROBE = 3'h2;
localparam ST_SETTLE = 3'h3;
localparam ST_HOLD = 3'h4;

reg [2:0] state;
reg [7:0] cnt;
reg is_rd;
reg [15:0] dq_s1;
reg [15:0] dq_s2;
reg [15:0] dq_s3;

////////////////////////////////////////////////////////////////////////////////
// data pins pass three flops; stable once second and third agree
always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        dq_s1 <= 16'h0000;
        dq_s2 <= 16'h0000;
        dq_s3 <= 16'h0000;
    end else begin
        dq_s1 <= flash_dq_in;
        dq_s2 <= dq_s1;
        dq_s3 <= dq_s2;
    end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        state <= ST_IDLE;
        cnt <= 8'h00;
        is_rd <= 1'b0;
        done <= 1'b0;
        rdata <= 16'h0000;
        flash_addr <= 20'h00000;
        flash_dq_out <= 16'h0000;
        flash_dq_oe_n <= 1'b1;
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1;
        flash_we_n <= 1'b1;
    end else begin
        done <= 1'b0;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    // address and data settle before any strobe falls
                    is_rd <= rd;
                    flash_addr <= addr;
                    flash_dq_out <= wdata;
                    flash_dq_oe_n <= rd;
                    flash_ce_n <= 1'b0;
                    state <= ST_SETUP;
                end
            end
            ST_SETUP: begin
                // later falling edge is we, so address latches here
                flash_we_n <= is_rd;
                flash_oe_n <= ~is_rd;
                cnt <= is_rd ? RD_CYC[7:0] : WP_CYC[7:0];
                state <= ST_STROBE;
            end
            ST_STROBE: begin
                if (cnt > 8'h01) begin
                    cnt <= cnt - 8'h01;
                end else if (is_rd) begin
                    cnt <= 8'h03;
                    state <= ST_SETTLE;
                end else begin
                    // we rises first while data still driven
                    flash_we_n <= 1'b1;
                    state <= ST_HOLD;
                end
            end
            ST_SETTLE: begin
                // covers synchroniser latency before sampling
                if (cnt > 8'h01) begin
                    cnt <= cnt - 8'h01;
                end else if (dq_s2 == dq_s3) begin
                    rdata <= dq_s3;
                    flash_oe_n <= 1'b1;
                    state <= ST_HOLD;
                end
            end
            ST_HOLD: begin
                flash_ce_n <= 1'b1;
                flash_dq_oe_n <= 1'b1;
                done <= 1'b1;
                state <= ST_IDLE;
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

endmodule // fec_bus_cycle

// [hw/fec_host.v]
// Notes on behaviour
// - sector erase: six writes, mode-dependent addresses
// - all cycles writes except reads, autoselect fourth
// - reset returns from autoselect or timeout
// - bypass program only after bypass entry
// - bypass program: A0, then data to address
`timescale 1ns/1ps
`include "fec_consts.vh"
module fec_host #(
    parameter BUSY_CYC = `FEC_BUSY_CYC
) (
    input wire core_clk,
    input wire rstn,
    input wire cmd_valid,
    input wire [3:0] cmd_op,
    input wire [19:0] cmd_addr,
    input wire [15:0] cmd_data,
    input wire word_mode,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg rsp_error,
    output reg [15:0] rsp_data,
    output reg erase_active,
    output reg erase_suspended,
    output reg bypass_active,
    output reg autoselect_active,
    output reg timeout_exceeded_flag,
    output wire [19:0] flash_addr,
    output wire [15:0] flash_dq_out,
    input wire [15:0] flash_dq_in,
    output wire flash_dq_oe_n,
    output wire flash_ce_n,
    output wire flash_oe_n,
    output wire flash_we_n,
    input wire flash_ready_busy
);
localparam ST_IDLE = 2'h0;
localparam ST_ISSUE = 2'h1;
localparam ST_WAIT = 2'h2;
localparam ST_FINISH = 2'h3;

reg [1:0] state;
reg [3:0] op;
reg [19:0] addr;
reg [15:0] data;
reg [2:0] step;
reg start;
reg [7:0] settle;
reg rb_s1;
reg rb_s2;
reg rb_s3;
reg rb_level;
reg legal;
reg [19:0] step_addr;
reg [15:0] step_data;
reg step_rd;
reg last_step;
wire cyc_done;
wire [15:0] cyc_rdata;
wire [19:0] unlock1;
wire [19:0] unlock2;
wire [19:0] sector_addr;

assign unlock1 = word_mode ? `FEC_UNLOCK1_WORD : `FEC_UNLOCK1_BYTE;
assign unlock2 = word_mode ? `FEC_UNLOCK2_WORD : `FEC_UNLOCK2_BYTE;
// low address bits cleared; only the sector bits matter
assign sector_addr = {addr[19:12], 12'h000};

////////////////////////////////////////////////////////////////////////////////
// ready/busy pin: three flops, level taken once second and third agree
always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        rb_s1 <= 1'b1;
        rb_s2 <= 1'b1;
        rb_s3 <= 1'b1;
        rb_level <= 1'b1;
    end else begin
        rb_s1 <= flash_ready_busy;
        rb_s2 <= rb_s1;
        rb_s3 <= rb_s2;
        if (rb_s2 == rb_s3) begin
            rb_level <= rb_s3;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// which operations the device will honour in the current mode
always @* begin
    legal = 1'b0;
    case (cmd_op)
        `FEC_OP_READ: legal = 1'b1;
        `FEC_OP_SECTOR_ERASE: legal = !erase_active && !bypass_active && !autoselect_active;
        `FEC_OP_SUSPEND: legal = erase_active && !erase_suspended;
        `FEC_OP_RESUME: legal = erase_suspended && !autoselect_active;
        `FEC_OP_BYP_ENTER: legal = !bypass_active && !erase_active && !autoselect_active;
        `FEC_OP_BYP_PROG: legal = bypass_active;
        `FEC_OP_BYP_EXIT: legal = bypass_active;
        `FEC_OP_RESET: legal = 1'b1;
        `FEC_OP_PROT_VERIFY: legal = !bypass_active && (!erase_active || erase_suspended);
        default: legal = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// bus cycle table; command cycles drive only the low data byte
always @* begin
    step_addr = 20'h00000;
    step_data = 16'h0000;
    step_rd = 1'b0;
    last_step = 1'b1;
    case (op)
        `FEC_OP_READ: begin
            step_addr = addr;
            step_rd = 1'b1;
        end
        `FEC_OP_SECTOR_ERASE: begin
            last_step = (step == 3'h5);
            case (step)
                3'h0: begin step_addr = unlock1; step_data = {8'h00, `FEC_D_UNLOCK1}; end
                3'h1: begin step_addr = unlock2; step_data = {8'h00, `FEC_D_UNLOCK2}; end
                3'h2: begin step_addr = unlock1; step_data = {8'h00, `FEC_D_ERASE_SETUP}; end
                3'h3: begin step_addr = unlock1; step_data = {8'h00, `FEC_D_UNLOCK1}; end
                3'h4: begin step_addr = unlock2; step_data = {8'h00, `FEC_D_UNLOCK2}; end
                default: begin step_addr = sector_addr; step_data = {8'h00, `FEC_D_SECTOR_ERASE}; end
            endcase
        end
        `FEC_OP_SUSPEND: step_data = {8'h00, `FEC_D_SUSPEND};
        `FEC_OP_RESUME: step_data = {8'h00, `FEC_D_RESUME};
        `FEC_OP_BYP_ENTER: begin
            last_step = (step == 3'h2);
            step_addr = (step == 3'h1) ? unlock2 : unlock1;
            case (step)
                3'h0: step_data = {8'h00, `FEC_D_UNLOCK1};
                3'h1: step_data = {8'h00, `FEC_D_UNLOCK2};
                default: step_data = {8'h00, `FEC_D_BYP_ENTER};
            endcase
        end
        `FEC_OP_BYP_PROG: begin
            last_step = (step == 3'h1);
            if (step == 3'h0) begin
                step_data = {8'h00, `FEC_D_BYP_PROG};
            end else begin
                step_addr = addr;
                step_data = data;
            end
        end
        `FEC_OP_BYP_EXIT: begin
            last_step = (step == 3'h1);
            step_data = (step == 3'h0) ? {8'h00, `FEC_D_BYP_EXIT1} : {8'h00, `FEC_D_BYP_EXIT2};
        end
        `FEC_OP_RESET: step_data = {8'h00, `FEC_D_RESET};
        `FEC_OP_PROT_VERIFY: begin
            last_step = (step == 3'h3);
            case (step)
                3'h0: begin step_addr = unlock1; step_data = {8'h00, `FEC_D_UNLOCK1}; end
                3'h1: begin step_addr = unlock2; step_data = {8'h00, `FEC_D_UNLOCK2}; end
                3'h2: begin step_addr = unlock1; step_data = {8'h00, `FEC_D_AUTOSELECT}; end
                default: begin
                    // fourth cycle is a read at the sector plus the protect offset
                    step_addr = sector_addr |
                        (word_mode ? `FEC_PROT_OFS_WORD : `FEC_PROT_OFS_BYTE);
                    step_rd = 1'b1;
                end
            endcase
        end
        default: last_step = 1'b1;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        state <= ST_IDLE;
        op <= `FEC_OP_READ;
        addr <= 20'h00000;
        data <= 16'h0000;
        step <= 3'h0;
        start <= 1'b0;
        settle <= 8'h00;
        cmd_ready <= 1'b1;
        rsp_valid <= 1'b0;
        rsp_error <= 1'b0;
        rsp_data <= 16'h0000;
        erase_active <= 1'b0;
        erase_suspended <= 1'b0;
        bypass_active <= 1'b0;
        autoselect_active <= 1'b0;
        timeout_exceeded_flag <= 1'b0;
    end else begin
        start <= 1'b0;
        rsp_valid <= 1'b0;
        rsp_error <= 1'b0;
        if (settle != 8'h00) begin
            settle <= settle - 8'h01;
        end
        case (state)
            ST_IDLE: begin
                // ready/busy only trusted after the busy window
                if (erase_active && !erase_suspended && settle == 8'h00 && rb_level) begin
                    erase_active <= 1'b0;
                end
                if (cmd_valid && cmd_ready) begin
                    if (legal) begin
                        op <= cmd_op;
                        addr <= cmd_addr;
                        data <= cmd_data;
                        step <= 3'h0;
                        cmd_ready <= 1'b0;
                        state <= ST_ISSUE;
                    end else begin
                        rsp_valid <= 1'b1;
                        rsp_error <= 1'b1;
                    end
                end
            end
            ST_ISSUE: begin
                start <= 1'b1;
                state <= ST_WAIT;
            end
            ST_WAIT: begin
                if (cyc_done) begin
                    if (last_step) begin
                        state <= ST_FINISH;
                    end else begin
                        step <= step + 3'h1;
                        state <= ST_ISSUE;
                    end
                end
            end
            ST_FINISH: begin
                rsp_valid <= 1'b1;
                cmd_ready <= 1'b1;
                state <= ST_IDLE;
                case (op)
                    `FEC_OP_READ: begin
                        rsp_data <= cyc_rdata;
                        // status reads while erasing carry the timeout bit
                        if (erase_active && !erase_suspended && cyc_rdata[`FEC_TIMEOUT_BIT]) begin
                            timeout_exceeded_flag <= 1'b1;
                        end
                    end
                    `FEC_OP_SECTOR_ERASE: begin
                        erase_active <= 1'b1;
                        settle <= BUSY_CYC[7:0];
                    end
                    `FEC_OP_SUSPEND: erase_suspended <= 1'b1;
                    `FEC_OP_RESUME: begin
                        erase_suspended <= 1'b0;
                        settle <= BUSY_CYC[7:0];
                    end
                    `FEC_OP_BYP_ENTER: bypass_active <= 1'b1;
                    `FEC_OP_BYP_EXIT: bypass_active <= 1'b0;
                    `FEC_OP_RESET: begin
                        // f0 also ends bypass mode
                        bypass_active <= 1'b0;
                        autoselect_active <= 1'b0;
                        timeout_exceeded_flag <= 1'b0;
                        if (timeout_exceeded_flag) begin
                            erase_active <= 1'b0;
                            erase_suspended <= 1'b0;
                        end
                    end
                    `FEC_OP_PROT_VERIFY: begin
                        autoselect_active <= 1'b1;
                        rsp_data <= {8'h00, cyc_rdata[7:0]};
                    end
                    default: rsp_data <= 16'h0000;
                endcase
            end
            default: state <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
fec_bus_cycle u_bus_cycle (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(start),
    .rd(step_rd),
    .addr(step_addr),
    .wdata(step_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_in(flash_dq_in),
    .flash_dq_oe_n(flash_dq_oe_n),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
);

endmodule // fec_host

// [sim/fec_host_monitor.sv]
`timescale 1ns/1ps
module fec_host_monitor (
    input wire core_clk,
    input wire rstn,
    input wire rsp_valid,
    input wire rsp_error,
    input wire erase_active,
    input wire erase_suspended,
    input wire [19:0] flash_addr,
    input wire [15:0] flash_dq_out,
    input wire flash_dq_oe_n,
    input wire flash_ce_n,
    input wire flash_oe_n,
    input wire flash_we_n
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    reg we_q;
    reg prog_next;
    // a write after A0 carries program data, upper byte free
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            we_q <= 1'h1;
            prog_next <= 1'h0;
        end else begin
            we_q <= flash_we_n;
            if (flash_we_n && !we_q) begin
                prog_next <= (flash_dq_out[7:0] == 8'hA0);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_we_in_ce;
        !flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n;
    endproperty
    a_we_in_ce: assert property (p_we_in_ce)
        else $error("write strobe without select or driven data");
    property p_read_released;
        !flash_oe_n |-> !flash_ce_n && flash_dq_oe_n && flash_we_n;
    endproperty
    a_read_released: assert property (p_read_released)
        else $error("read strobe while host drives data");
    property p_wr_hold;
        !flash_we_n && $past(!flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("address or data moved inside write pulse");
    property p_we_width;
        $fell(flash_we_n) |-> !flash_we_n [*2] ##1 flash_we_n;
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write pulse width wrong");
    property p_upper_zero;
        !flash_we_n && !prog_next |-> flash_dq_out[15:8] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper data byte not zero in command write");
    // data must still be held when the strobe rises, so select drops a cycle later
    property p_ce_after_we;
        $rose(flash_we_n) |=> flash_ce_n && flash_dq_oe_n;
    endproperty
    a_ce_after_we: assert property (p_ce_after_we)
        else $error("select not released one cycle after write strobe");
    property p_refused_quiet;
        rsp_error |-> rsp_valid && flash_ce_n && $past(flash_ce_n);
    endproperty
    a_refused_quiet: assert property (p_refused_quiet)
        else $error("refused request touched the flash pins");
    property p_susp_in_erase;
        erase_suspended |-> erase_active;
    endproperty
    a_susp_in_erase: assert property (p_susp_in_erase)
        else $error("suspended flag without erase");
endmodule // fec_host_monitor

// [sim/fec_flash_model.sv]
`timescale 1ns/1ps
module fec_flash_model #(
    parameter ERASE_CYC = 60,
    parameter PROT_SECTOR = 8'h03
) (
    input wire core_clk,
    input wire word_mode,
    input wire inject_tmo,
    input wire [19:0] addr,
    input wire [15:0] dq_w,
    input wire ce_n,
    input wire oe_n,
    input wire we_n,
    output wire [15:0] dq_r,
    output wire ready_busy,
    output reg [7:0] sector
);
    reg [19:0] la = 20'h00000;
    reg [19:0] pa = 20'hFFFFF;
    reg [15:0] pd = 16'h0000;
    reg [15:0] last = 16'h0000;
    reg [2:0] n = 3'h0;
    reg armed = 1'h0, erasing = 1'h0, susp = 1'h0, byp = 1'h0, pend = 1'h0, ex = 1'h0;
    reg auto = 1'h0;
    integer tmr = 0;
    wire [11:0] u1 = word_mode ? 12'h555 : 12'hAAA;
    wire [11:0] u2 = word_mode ? 12'h2AA : 12'h555;
    wire pv_hit = addr[7:0] == (word_mode ? 8'h02 : 8'h04);
    wire [15:0] rv;
    ////////////////////////////////////////////////////////////////////////////////
    assign rv = auto ? (pv_hit ? {15'h0000, addr[19:12] == PROT_SECTOR} : 16'hFFFF) :
        (erasing && !susp) ? {10'h000, inject_tmo, 5'h00} :
        (addr == pa) ? pd : addr[15:0] ^ 16'h5A3C;
    // released bus shows the inverse, so a late capture cannot pass by luck
    assign dq_r = (!oe_n && !ce_n) ? rv : ~last;
    assign ready_busy = !(erasing && !susp);
    always @(posedge oe_n)
        last = rv;
    ////////////////////////////////////////////////////////////////////////////////
    task do_write(input [19:0] a, input [15:0] w);
        begin
            if (byp && pend) begin
                pa = a;
                pd = w;
                pend = 1'h0;
            end else if (byp) begin
                pend = (w[7:0] == 8'hA0);
                if ((ex && w[7:0] == 8'h00) || w[7:0] == 8'hF0)
                    byp = 1'h0;
                ex = (w[7:0] == 8'h90);
            end else if (w[7:0] == 8'hF0) begin
                auto = 1'h0;
                erasing = 1'h0;
                susp = 1'h0;
                n = 3'h0;
            end else if (erasing && !susp && w[7:0] == 8'hB0) begin
                susp = 1'h1;
            end else if (susp && n == 3'h0 && w[7:0] == 8'h30) begin
                susp = 1'h0;
            end else if (n == 3'h0 || n == 3'h3) begin
                n = (a[11:0] == u1 && w[7:0] == 8'hAA) ? n + 3'h1 : 3'h0;
            end else if (n == 3'h1 || n == 3'h4) begin
                n = (a[11:0] == u2 && w[7:0] == 8'h55) ? n + 3'h1 : 3'h0;
            end else if (n == 3'h2) begin
                n = (a[11:0] == u1 && w[7:0] == 8'h80) ? 3'h3 : 3'h0;
                byp = (a[11:0] == u1 && w[7:0] == 8'h20);
                auto = (a[11:0] == u1 && w[7:0] == 8'h90);
            end else begin
                n = 3'h0;
                erasing = (w[7:0] == 8'h30);
                sector = a[19:12];
                tmr = ERASE_CYC;
            end
        end
    endtask
    always @(negedge we_n or negedge ce_n)
        if (!we_n && !ce_n && oe_n) begin
            la = addr;
            armed = 1'h1;
        end
    always @(posedge we_n or posedge ce_n)
        if (armed) begin
            armed = 1'h0;
            do_write(la, dq_w);
        end
    // a timed-out erase never finishes on its own
    always @(posedge core_clk)
        if (erasing && !susp && !inject_tmo) begin
            tmr = tmr - 1;
            if (tmr <= 0)
                erasing = 1'h0;
        end
endmodule // fec_flash_model

// [sim/fec_host_tb.sv]
`timescale 1ns/1ps
`include "fec_consts.vh"
module fec_host_tb;
    reg core_clk = 1'h0;
    reg rstn = 1'h0;
    reg cmd_valid = 1'h0;
    reg [3:0] cmd_op = 4'h0;
    reg [19:0] cmd_addr = 20'h00000;
    reg [15:0] cmd_data = 16'h0000;
    reg word_mode = 1'h0;
    reg inject_tmo = 1'h0;
    reg err;
    reg [15:0] rd;
    wire cmd_ready, rsp_valid, rsp_error, erase_active, erase_suspended, bypass_active;
    wire autoselect_active, timeout_exceeded_flag, flash_dq_oe_n, flash_ce_n, flash_oe_n;
    wire flash_we_n, flash_ready_busy;
    wire [15:0] rsp_data, flash_dq_out, flash_dq_in, bus_w;
    wire [19:0] flash_addr;
    wire [7:0] sector;
    integer failures = 0;
    integer checks = 0;
    integer cyc = 0;
    always #10 core_clk = ~core_clk;
    // undriven bus seen inverted by the model
    assign bus_w = flash_dq_oe_n ? ~flash_dq_out : flash_dq_out;
    fec_host dut (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .word_mode(word_mode),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
        .rsp_data(rsp_data), .erase_active(erase_active), .erase_suspended(erase_suspended),
        .bypass_active(bypass_active), .autoselect_active(autoselect_active),
        .timeout_exceeded_flag(timeout_exceeded_flag), .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in),
        .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .flash_ready_busy(flash_ready_busy));
    fec_flash_model flash (.core_clk(core_clk), .word_mode(word_mode),
        .inject_tmo(inject_tmo), .addr(flash_addr), .dq_w(bus_w), .ce_n(flash_ce_n),
        .oe_n(flash_oe_n), .we_n(flash_we_n), .dq_r(flash_dq_in),
        .ready_busy(flash_ready_busy), .sector(sector));
    ////////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            wrap_up;
        end
    end
    task chk(input [16:0] seen, input [16:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("ERROR at %0t ns: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // one request; ready is high since the previous answer already came
    task issue(input [3:0] op, input [19:0] a, input [15:0] d);
        integer i;
        begin
            @(posedge core_clk) #1;
            cmd_op = op;
            cmd_addr = a;
            cmd_data = d;
            cmd_valid = 1'h1;
            @(posedge core_clk) #1;
            cmd_valid = 1'h0;
            for (i = 0; i < 300 && rsp_valid !== 1'h1; i = i + 1)
                @(posedge core_clk) #1;
            err = rsp_error;
            rd = rsp_data;
            chk({rsp_valid, cmd_ready}, 2'h3);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_read;
        begin
            issue(`FEC_OP_READ, 20'h12345, 16'h0000);
            chk({err, rd}, {1'h0, 16'h2345 ^ 16'h5A3C});
        end
    endtask
    task t_erase(input m);
        integer i;
        begin
            word_mode = m;
            issue(`FEC_OP_SECTOR_ERASE, 20'hAB123, 16'h0000);
            chk({err, erase_active, flash_ready_busy}, 3'h2);
            chk(sector, 8'hAB);
            issue(`FEC_OP_SUSPEND, 20'h00000, 16'h0000);
            chk({err, erase_suspended, flash_ready_busy}, 3'h3);
            issue(`FEC_OP_READ, 20'h00100, 16'h0000);
            chk(rd, 16'h0100 ^ 16'h5A3C);
            issue(`FEC_OP_SUSPEND, 20'h00000, 16'h0000);
            chk(err, 1'h1);
            issue(`FEC_OP_RESUME, 20'h00000, 16'h0000);
            chk({err, erase_suspended, flash_ready_busy}, 3'h0);
            issue(`FEC_OP_RESUME, 20'h00000, 16'h0000);
            chk(err, 1'h1);
            for (i = 0; i < 300 && erase_active !== 1'h0; i = i + 1)
                @(posedge core_clk) #1;
            chk({erase_active, flash_ready_busy}, 2'h1);
        end
    endtask
    task t_bypass;
        begin
            word_mode = 1'h0;
            issue(`FEC_OP_BYP_PROG, 20'h04444, 16'hBEEF);
            chk(err, 1'h1);
            issue(`FEC_OP_BYP_ENTER, 20'h00000, 16'h0000);
            chk({err, bypass_active}, 2'h1);
            issue(`FEC_OP_BYP_PROG, 20'h04444, 16'hBEEF);
            issue(`FEC_OP_READ, 20'h04444, 16'h0000);
            chk({err, rd}, {1'h0, 16'hBEEF});
            issue(`FEC_OP_SECTOR_ERASE, 20'h10000, 16'h0000);
            chk(err, 1'h1);
            issue(`FEC_OP_BYP_EXIT, 20'h00000, 16'h0000);
            chk({err, bypass_active}, 2'h0);
            issue(`FEC_OP_BYP_ENTER, 20'h00000, 16'h0000);
            issue(`FEC_OP_RESET, 20'h00000, 16'h0000);
            chk({err, bypass_active}, 2'h0);
        end
    endtask
    // runs right after the reset that ends bypass: the unlock only works if the device left bypass
    task t_protect;
        begin
            issue(`FEC_OP_PROT_VERIFY, 20'h03000, 16'h0000);
            chk({autoselect_active, rd}, {1'h1, 16'h0001});
            issue(`FEC_OP_PROT_VERIFY, 20'h05000, 16'h0000);
            chk({err, rd}, {1'h0, 16'h0000});
            issue(`FEC_OP_RESET, 20'h00000, 16'h0000);
            chk(autoselect_active, 1'h0);
            issue(`FEC_OP_READ, 20'h03000, 16'h0000);
            chk(rd, 16'h3000 ^ 16'h5A3C);
        end
    endtask
    task t_timeout;
        begin
            inject_tmo = 1'h1;
            issue(`FEC_OP_SECTOR_ERASE, 20'h22000, 16'h0000);
            issue(`FEC_OP_READ, 20'h22000, 16'h0000);
            chk(timeout_exceeded_flag, 1'h1);
            issue(`FEC_OP_RESET, 20'h00000, 16'h0000);
            chk({timeout_exceeded_flag, erase_active}, 2'h0);
            inject_tmo = 1'h0;
            issue(`FEC_OP_READ, 20'h22000, 16'h0000);
            chk(rd, 16'h2000 ^ 16'h5A3C);
        end
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rstn = 1'h1;
        t_read;
        t_erase(1'h0);
        t_erase(1'h1);
        t_bypass;
        t_protect;
        t_timeout;
        wrap_up;
    end
endmodule // fec_host_tb
bind fec_host fec_host_monitor mon (.core_clk(core_clk), .rstn(rstn), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .erase_active(erase_active), .erase_suspended(erase_suspended),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
